// File: design/pcr_sink.sv
/*
  sink end: acknowledges messages, drops to standby, guards the
  transition with a timer and paces load steps at the new level.
  assumes manager inputs come from logic on sys_clk.
*/
// How it works
// - source sends accept to begin
// - sink starts guard timer on accept
// - every accept and ps_rdy gets acknowledged
// - source waits transition time after ack
// - sink reaches standby before transition ends
// - source commands voltage, supply ready in time
// - ps_rdy only after supply ready
// - sink evaluates ps_rdy, then permits new level
// - new draw allowed only after ps_rdy
// - load steps kept within transient limits
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_sink (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  pcr_link_if.snk   link,
  input  wire logic stdby_done,
  input  wire logic load_step_req,
  input  wire logic err_clear,
  output logic      stdby_req,
  output logic      new_power_ok,
  output logic      load_step_grant,
  output logic      xfer_err,
  output logic      stdby_late,
  output logic      busy
);
  typedef struct packed {
    pcr_pkg::pcr_snk_st_t st;
    logic                 crc;
    logic                 stdby;
    logic                 ok;
    logic                 grant;
    logic                 err;
    logic                 late;
  } pcr_snk_t;

  pcr_snk_t          q;
  pcr_snk_t          d;
  logic              got_acc;
  logic              got_rdy;
  logic              ps_start;
  logic              ps_stop;
  logic              ps_exp;
  logic              aux_start;
  logic              aux_stop;
  logic              aux_run;
  logic              aux_exp;
  pcr_pkg::pcr_cnt_t aux_load;

  assign got_acc = link.msg_valid &&
                   (link.msg_type == pcr_pkg::PCR_MSG_ACCEPT);
  assign got_rdy = link.msg_valid &&
                   (link.msg_type == pcr_pkg::PCR_MSG_PS_RDY);

  // guard from accept to ps_rdy
  pcr_timer u_ps_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (ps_start),
    .load    (`PCR_CNT_W'(`PCR_T_PS_TRANS_CYC)),
    .stop    (ps_stop),
    .running (),
    .expired (ps_exp)
  );

  // shared: standby deadline, then load-step spacing
  pcr_timer u_aux_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (aux_start),
    .load    (aux_load),
    .stop    (aux_stop),
    .running (aux_run),
    .expired (aux_exp)
  );

  always_comb
  begin
    d         = q;
    d.grant   = 1'h0;
    ps_start  = 1'h0;
    ps_stop   = 1'h0;
    aux_start = 1'h0;
    aux_stop  = 1'h0;
    aux_load  = `PCR_CNT_W'(`PCR_T_SNK_STDBY_CYC);

    d.crc = link.msg_valid;

    // clear first so a same-cycle set below wins
    if (err_clear)
    begin
      d.err  = 1'h0;
      d.late = 1'h0;
    end

    unique case (q.st)
      pcr_pkg::PCR_K_IDLE,
      pcr_pkg::PCR_K_OPERATE:
      begin
        if (got_acc)
        begin
          ps_start = 1'h1;
          aux_stop = 1'h1;
          d.ok     = 1'h0;
          d.st     = pcr_pkg::PCR_K_EVAL_ACC;
        end
        else if (q.st == pcr_pkg::PCR_K_OPERATE &&
                 load_step_req && !aux_run)
        begin
          d.grant   = 1'h1;
          aux_start = 1'h1;
          aux_load  = `PCR_CNT_W'(`PCR_T_LOAD_STEP_CYC);
        end
      end
      pcr_pkg::PCR_K_EVAL_ACC:
      begin
        d.stdby   = 1'h1;
        aux_start = 1'h1;
        d.st      = pcr_pkg::PCR_K_STDBY;
      end
      pcr_pkg::PCR_K_STDBY:
      begin
        if (ps_exp)
        begin
          aux_stop = 1'h1;
          d.stdby  = 1'h0;
          d.err    = 1'h1;
          d.st     = pcr_pkg::PCR_K_IDLE;
        end
        else if (got_rdy)
        begin
          aux_stop = 1'h1;
          ps_stop  = 1'h1;
          d.st     = pcr_pkg::PCR_K_EVAL_RDY;
        end
        else if (stdby_done)
        begin
          aux_stop = 1'h1;
          d.st     = pcr_pkg::PCR_K_WAIT_RDY;
        end
        else if (aux_exp)
        begin
          d.late = 1'h1;
          d.st   = pcr_pkg::PCR_K_WAIT_RDY;
        end
      end
      pcr_pkg::PCR_K_WAIT_RDY:
      begin
        if (got_rdy)
        begin
          ps_stop = 1'h1;
          d.st    = pcr_pkg::PCR_K_EVAL_RDY;
        end
        else if (ps_exp)
        begin
          d.stdby = 1'h0;
          d.err   = 1'h1;
          d.st    = pcr_pkg::PCR_K_IDLE;
        end
      end
      pcr_pkg::PCR_K_EVAL_RDY:
      begin
        d.stdby = 1'h0;
        d.ok    = 1'h1;
        d.st    = pcr_pkg::PCR_K_OPERATE;
      end
      default:
      begin
        d.st = pcr_pkg::PCR_K_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q    <= '0;
      q.st <= pcr_pkg::PCR_K_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.crc_ack    = q.crc;
  assign stdby_req       = q.stdby;
  assign new_power_ok    = q.ok;
  assign load_step_grant = q.grant;
  assign xfer_err        = q.err;
  assign stdby_late      = q.late;
  assign busy            = (q.st != pcr_pkg::PCR_K_IDLE) &&
                           (q.st != pcr_pkg::PCR_K_OPERATE);
endmodule : pcr_sink

// File: design/pcr_params.svh
/*
  timing counts for the power contract raise sequence, as macros.
  assumes the block clock sys_clk runs at 25 MHz; every count fits 12 bits.
*/
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

`define PCR_CLK_NS          40
`define PCR_CNT_W           12

// least wait from accept ack to supply command (rounded up)
`define PCR_T_SNK_TRANS_US  100
`define PCR_T_SNK_TRANS_CYC \
  (((`PCR_T_SNK_TRANS_US*1000)+`PCR_CLK_NS-1)/`PCR_CLK_NS)

// longest time the sink may take to reach standby (rounded down)
`define PCR_T_SNK_STDBY_US  80
`define PCR_T_SNK_STDBY_CYC ((`PCR_T_SNK_STDBY_US*1000)/`PCR_CLK_NS)

// longest time the supply may take to be ready (rounded down)
`define PCR_T_SRC_READY_US  160
`define PCR_T_SRC_READY_CYC ((`PCR_T_SRC_READY_US*1000)/`PCR_CLK_NS)

// sink guard timer from accept to ps_rdy (rounded down)
`define PCR_T_PS_TRANS_US   163
`define PCR_T_PS_TRANS_CYC  ((`PCR_T_PS_TRANS_US*1000)/`PCR_CLK_NS)

// least spacing between two granted load steps (rounded up)
`define PCR_T_LOAD_STEP_US  20
`define PCR_T_LOAD_STEP_CYC \
  (((`PCR_T_LOAD_STEP_US*1000)+`PCR_CLK_NS-1)/`PCR_CLK_NS)

`endif

// File: design/pcr_pkg.sv
/*
  types shared by both ends of the power contract raise link.
  assumes pcr_params.svh is compiled alongside for the widths.
*/
`include "pcr_params.svh"

package pcr_pkg;

  typedef logic [`PCR_CNT_W-1:0] pcr_cnt_t;

  typedef enum logic [0:0] {
    PCR_MSG_ACCEPT = 1'h0,
    PCR_MSG_PS_RDY = 1'h1
  } pcr_msg_t;

  typedef enum logic [2:0] {
    PCR_S_IDLE    = 3'h0,
    PCR_S_ACC_CRC = 3'h1,
    PCR_S_TRANS   = 3'h2,
    PCR_S_SUPPLY  = 3'h3,
    PCR_S_RDY_CRC = 3'h4
  } pcr_src_st_t;

  typedef enum logic [2:0] {
    PCR_K_IDLE     = 3'h0,
    PCR_K_EVAL_ACC = 3'h1,
    PCR_K_STDBY    = 3'h2,
    PCR_K_WAIT_RDY = 3'h3,
    PCR_K_EVAL_RDY = 3'h4,
    PCR_K_OPERATE  = 3'h5
  } pcr_snk_st_t;

endpackage : pcr_pkg

// File: design/pcr_link_if.sv
/*
  message link between the source end and the sink end.
  assumes both ends share sys_clk; every signal is a one-cycle pulse
  except msg_type, which is valid with msg_valid.
*/
`timescale 1ns/1ps

interface pcr_link_if (
  input wire logic sys_clk
);
  logic              msg_valid;
  pcr_pkg::pcr_msg_t msg_type;
  logic              crc_ack;

  modport src (
    output msg_valid,
    output msg_type,
    input  crc_ack
  );

  modport snk (
    input  msg_valid,
    input  msg_type,
    output crc_ack
  );
endinterface : pcr_link_if

// File: design/pcr_timer.sv
/*
  one-shot down counter used for the sequence waits.
  assumes load is at least one; expired pulses load+1 cycles after start.
*/
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_timer (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            start,
  input  wire pcr_pkg::pcr_cnt_t load,
  input  wire logic            stop,
  output logic                 running,
  output logic                 expired
);
  typedef struct packed {
    logic              run;
    pcr_pkg::pcr_cnt_t cnt;
    logic              exp;
  } pcr_tmr_t;

  pcr_tmr_t q;
  pcr_tmr_t d;

  always_comb
  begin
    d     = q;
    d.exp = 1'h0;
    // start beats a stale expiry so a restart never fires early
    if (stop)
    begin
      d.run = 1'h0;
    end
    else if (start)
    begin
      d.run = 1'h1;
      d.cnt = load;
    end
    else if (q.run)
    begin
      if (q.cnt <= `PCR_CNT_W'h1)
      begin
        d.run = 1'h0;
        d.exp = 1'h1;
      end
      else
      begin
        d.cnt = q.cnt - `PCR_CNT_W'h1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign running = q.run;
  assign expired = q.exp;
endmodule : pcr_timer

// File: design/pcr_source.sv
/*
  source end: accepts the pending request, waits, raises the supply,
  then reports ready to the sink.
  assumes accept_req and supply_ready come from logic on sys_clk.
*/
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_source (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  pcr_link_if.src   link,
  input  wire logic accept_req,
  input  wire logic supply_ready,
  output logic      supply_cmd,
  output logic      busy,
  output logic      done,
  output logic      supply_late
);
  typedef struct packed {
    pcr_pkg::pcr_src_st_t st;
    logic                 msg_valid;
    pcr_pkg::pcr_msg_t    msg_type;
    logic                 cmd;
    logic                 done;
    logic                 late;
  } pcr_src_t;

  pcr_src_t          q;
  pcr_src_t          d;
  logic              tmr_start;
  logic              tmr_stop;
  pcr_pkg::pcr_cnt_t tmr_load;
  logic              tmr_exp;

  pcr_timer u_tmr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (tmr_start),
    .load    (tmr_load),
    .stop    (tmr_stop),
    .running (),
    .expired (tmr_exp)
  );

  always_comb
  begin
    d           = q;
    d.msg_valid = 1'h0;
    d.done      = 1'h0;
    tmr_start   = 1'h0;
    tmr_stop    = 1'h0;
    tmr_load    = `PCR_CNT_W'(`PCR_T_SNK_TRANS_CYC);
    unique case (q.st)
      pcr_pkg::PCR_S_IDLE:
      begin
        if (accept_req)
        begin
          d.msg_valid = 1'h1;
          d.msg_type  = pcr_pkg::PCR_MSG_ACCEPT;
          d.late      = 1'h0;
          d.st        = pcr_pkg::PCR_S_ACC_CRC;
        end
      end
      pcr_pkg::PCR_S_ACC_CRC:
      begin
        if (link.crc_ack)
        begin
          tmr_start = 1'h1;
          d.st      = pcr_pkg::PCR_S_TRANS;
        end
      end
      pcr_pkg::PCR_S_TRANS:
      begin
        if (tmr_exp)
        begin
          d.cmd     = 1'h1;
          tmr_start = 1'h1;
          tmr_load  = `PCR_CNT_W'(`PCR_T_SRC_READY_CYC);
          d.st      = pcr_pkg::PCR_S_SUPPLY;
        end
      end
      pcr_pkg::PCR_S_SUPPLY:
      begin
        if (supply_ready)
        begin
          tmr_stop    = 1'h1;
          d.msg_valid = 1'h1;
          d.msg_type  = pcr_pkg::PCR_MSG_PS_RDY;
          d.st        = pcr_pkg::PCR_S_RDY_CRC;
        end
        else if (tmr_exp)
        begin
          d.late = 1'h1;
        end
      end
      pcr_pkg::PCR_S_RDY_CRC:
      begin
        if (link.crc_ack)
        begin
          d.cmd  = 1'h0;
          d.done = 1'h1;
          d.st   = pcr_pkg::PCR_S_IDLE;
        end
      end
      default:
      begin
        d.st = pcr_pkg::PCR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q          <= '0;
      q.st       <= pcr_pkg::PCR_S_IDLE;
      q.msg_type <= pcr_pkg::PCR_MSG_ACCEPT;
    end
    else
    begin
      q <= d;
    end
  end

  assign link.msg_valid = q.msg_valid;
  assign link.msg_type  = q.msg_type;
  assign supply_cmd     = q.cmd;
  assign busy           = (q.st != pcr_pkg::PCR_S_IDLE);
  assign done           = q.done;
  assign supply_late    = q.late;
endmodule : pcr_source

// File: testbench/pcr_link_props.sv
/*
  checker on the link and supply handshake of the raise sequence.
  assumes one sys_clk domain and a synchronous active-low rst_n.
*/
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_link_props (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              msg_valid,
  input wire pcr_pkg::pcr_msg_t msg_type,
  input wire logic              crc_ack,
  input wire logic              supply_ready,
  input wire logic              supply_cmd,
  input wire logic              done,
  input wire logic              stdby_req,
  input wire logic              new_power_ok
);
  localparam int TW = `PCR_T_SNK_TRANS_CYC;
  logic [12:0] gap_q;
  wire         rdy = msg_type == pcr_pkg::PCR_MSG_PS_RDY;

  // saturates so a stale ack never looks recent
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      gap_q <= '1;
    else if (crc_ack && !rdy)
      gap_q <= '0;
    else if (gap_q != '1)
      gap_q <= gap_q + 13'h1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_ack_next; msg_valid |=> crc_ack; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("message not acked");
  property p_ack_cause; crc_ack |-> $past(msg_valid); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without message");
  property p_rdy_gate;
    msg_valid && rdy |-> $past(supply_ready) && $past(supply_cmd);
  endproperty
  a_rdy_gate: assert property (p_rdy_gate)
    else $error("ready message before supply ready");
  property p_wait;
    $rose(supply_cmd) |-> gap_q >= TW && gap_q <= TW + 4;
  endproperty
  a_wait: assert property (p_wait)
    else $error("supply command off transition wait");
  property p_stdby; $rose(stdby_req) |-> $past(crc_ack) && !rdy; endproperty
  a_stdby: assert property (p_stdby)
    else $error("standby not caused by accept");
  property p_ok; $rose(new_power_ok) |-> $past(crc_ack) && rdy; endproperty
  a_ok: assert property (p_ok)
    else $error("new level permitted early");
  property p_done; done |-> $past(crc_ack) && rdy; endproperty
  a_done: assert property (p_done)
    else $error("done without ready ack");
  property p_drop; $fell(supply_cmd) |-> done; endproperty
  a_drop: assert property (p_drop)
    else $error("supply command dropped early");
endmodule : pcr_link_props

// File: testbench/power_contract_raise_sequence_tb.sv
/*
  bench joining source and sink ends over the link, with a small model.
  assumes the header counts as shipped; run is about 15k cycles.
*/
`timescale 1ns/1ps
`include "pcr_params.svh"

module power_contract_raise_sequence_tb;
  localparam int T_RDY = `PCR_T_SRC_READY_CYC;
  logic   sys_clk, rst_n, accept_req, supply_ready, err_clear;
  logic   stdby_done, load_step_req, supply_cmd, done, supply_late;
  logic   stdby_req, new_power_ok, load_step_grant, xfer_err;
  logic   stdby_late, src_busy, snk_busy;
  int     err_count, num_checks, cyc, grants, last_g, gap_min;
  int     pre_grant;
  integer seed;
  pcr_pkg::pcr_msg_t msg_q[$];
  pcr_pkg::pcr_msg_t exp_q[$];

  pcr_link_if u_pcr_link_if (.sys_clk(sys_clk));
  pcr_source u_pcr_source (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(u_pcr_link_if),
    .accept_req(accept_req), .supply_ready(supply_ready),
    .supply_cmd(supply_cmd), .busy(src_busy), .done(done),
    .supply_late(supply_late));
  pcr_sink u_pcr_sink (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(u_pcr_link_if),
    .stdby_done(stdby_done), .load_step_req(load_step_req),
    .err_clear(err_clear), .stdby_req(stdby_req),
    .new_power_ok(new_power_ok), .load_step_grant(load_step_grant),
    .xfer_err(xfer_err), .stdby_late(stdby_late), .busy(snk_busy));
  pcr_link_props u_pcr_link_props (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .msg_valid(u_pcr_link_if.msg_valid),
    .msg_type(u_pcr_link_if.msg_type),
    .crc_ack(u_pcr_link_if.crc_ack), .supply_ready(supply_ready),
    .supply_cmd(supply_cmd), .done(done), .stdby_req(stdby_req),
    .new_power_ok(new_power_ok));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // sampled on the falling edge so the edge's updates have landed
  always @(negedge sys_clk)
  begin
    cyc++;
    if (u_pcr_link_if.msg_valid === 1'b1)
      msg_q.push_back(u_pcr_link_if.msg_type);
    if (load_step_grant === 1'b1)
    begin
      if (new_power_ok !== 1'b1)
        pre_grant++;
      if (grants > 0 && cyc - last_g < gap_min)
        gap_min = cyc - last_g;
      grants++;
      last_g = cyc;
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_hi(ref logic s, input int lim);
    int i;
    i = 0;
    while (s !== 1'b1 && i < lim)
    begin
      @(negedge sys_clk);
      i++;
    end
    if (s !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH %0t wait ran out", $time);
      end_of_test();
    end
  endtask : wait_hi

  // one full raise; a late supply also trips the sink guard timer
  task automatic raise(input int sup_dly, input logic give_sb);
    int sb_dly;
    logic late;
    late = sup_dly > T_RDY;
    sb_dly = 10 + ($unsigned($random(seed)) % 1400);
    msg_q.delete();
    exp_q = '{pcr_pkg::PCR_MSG_ACCEPT, pcr_pkg::PCR_MSG_PS_RDY};
    @(posedge sys_clk);
    accept_req <= 1'b1;
    @(posedge sys_clk);
    accept_req <= 1'b0;
    repeat (sb_dly) @(posedge sys_clk);
    stdby_done <= give_sb;
    accept_req <= 1'b1;
    load_step_req <= 1'($random(seed));
    @(posedge sys_clk);
    accept_req <= 1'b0;
    load_step_req <= 1'b0;
    wait_hi(supply_cmd, 3000);
    check(src_busy, 1'b1);
    check(snk_busy, 1'b1);
    check(stdby_req, 1'b1);
    repeat (sup_dly) @(posedge sys_clk);
    supply_ready <= 1'b1;
    wait_hi(done, 20);
    @(posedge sys_clk);
    supply_ready <= 1'b0;
    stdby_done <= 1'b0;
    repeat (4) @(negedge sys_clk);
    check(msg_q.size(), exp_q.size());
    foreach (exp_q[k])
      check(msg_q[k], exp_q[k]);
    check(supply_late, late);
    check(xfer_err, late);
    check(stdby_late, !give_sb);
    check(new_power_ok, !late);
    check(supply_cmd, 1'b0);
    check(src_busy, 1'b0);
    check(snk_busy, 1'b0);
    check(stdby_req, 1'b0);
  endtask : raise

  initial
  begin
    seed = 32'h3806;
    rst_n = 1'b0;
    accept_req = 1'b0;
    supply_ready = 1'b0;
    stdby_done = 1'b0;
    load_step_req = 1'b0;
    err_clear = 1'b0;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    grants = 0;
    last_g = 0;
    gap_min = 99999;
    pre_grant = 0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(new_power_ok, 1'b0);
    raise(1 + ($unsigned($random(seed)) % 1400), 1'b1);
    grants = 0;
    @(posedge sys_clk);
    load_step_req <= 1'b1;
    repeat (1200) @(posedge sys_clk);
    load_step_req <= 1'b0;
    @(negedge sys_clk);
    check(grants, (1200 + `PCR_T_LOAD_STEP_CYC) /
          (`PCR_T_LOAD_STEP_CYC + 1));
    check(gap_min > `PCR_T_LOAD_STEP_CYC, 1'b1);
    raise(T_RDY + 200, 1'b0);
    @(posedge sys_clk);
    err_clear <= 1'b1;
    @(posedge sys_clk);
    err_clear <= 1'b0;
    @(negedge sys_clk);
    check(xfer_err, 1'b0);
    check(stdby_late, 1'b0);
    check(supply_late, 1'b1);
    raise(1 + ($unsigned($random(seed)) % 1400), 1'b1);
    check(pre_grant, 0);
    end_of_test();
  end
endmodule : power_contract_raise_sequence_tb
